/* logic/dmd_attr_regs.sv */
// Host-side storage and attribute logic of an eight-digit 5x7 dot-matrix display.
// Assumes the host pins are asynchronous to clk_sys and the scan logic shares clk_sys.
`timescale 1ns/1ps
`default_nettype none

module dmd_attr_regs
    import dmd_pkg::*;
#(
    parameter int DISP_DIV   = `DMD_DISP_DIV,
    parameter int FLASH_DIV  = `DMD_FLASH_DIV,
    parameter int TEST_TICKS = `DMD_TEST_TICKS,
    parameter logic [15:0] ROM_SUM = dmd_font_sum()
)
(
    input  wire logic        clk_sys,               // 40 MHz system clock.
    input  wire logic        resetn,                // Synchronous reset, active low.
    input  wire logic        chip_enable_n,         // Chip select pin.
    input  wire logic        write_n,               // Write strobe pin.
    input  wire logic        read_n,                // Read strobe pin.
    input  wire logic        flash_region_select_n, // Flash memory select pin.
    input  wire logic        region_select_hi,      // Upper region line.
    input  wire logic        region_select_lo,      // Lower region line.
    input  wire logic [2:0]  sub_address,           // Digit or row address.
    input  wire logic [7:0]  data_in,               // Data bus, pin level.
    output logic      [7:0]  data_out,              // Data bus, driven value.
    output logic             data_oe,               // Data bus drive enable.
    input  wire logic [2:0]  scan_digit,            // Scan: digit to fetch.
    input  wire logic [3:0]  scan_glyph,            // Scan: glyph slot to fetch.
    input  wire logic [2:0]  scan_row,              // Scan: glyph row 0..6.
    output logic      [7:0]  scan_char,             // Character entry of scan_digit.
    output logic      [4:0]  scan_dots,             // Lit dots of the scanned glyph row.
    output logic      [7:0]  digit_on,              // Per-digit column enable.
    output logic             test_pattern,          // Self-test pattern shown.
    output logic             test_inverse,          // Inverse checkerboard phase.
    output logic             self_test_busy         // Self test in progress.
);

    localparam int GLYPHS = 16;
    localparam int SLOTS  = GLYPHS * `DMD_GLYPH_ROWS;

    logic [16:0] sync1_q;
    logic [16:0] sync2_q;
    logic        wr_prev_q;
    logic        ce_n_s;
    logic        wr_n_s;
    logic        rd_n_s;
    logic [2:0]  sub_s;
    logic [7:0]  din_s;
    dmd_area_t   area_s;
    logic        wr_take;
    logic        rd_active;

    logic [3:0]  custom_glyph_pointer_q;
    logic [7:0]  attribute_control_word_q;
    logic [7:0]  flash_flags_q;
    logic [7:0]  char_mem [0:7];
    logic [4:0]  glyph_mem [0:SLOTS-1];
    logic [1:0]  clear_cnt_q;
    logic        clear_go_q;
    logic [15:0] sum_q;
    logic [3:0]  pwm_q;

    logic [2:0]  brightness_code;
    logic        flash_enable;
    logic        blink_enable;
    logic        self_test_start;
    logic        disp_tick;
    logic        flash_phase;
    logic        test_busy;
    logic [17:0] test_count;
    logic        test_done;
    logic        test_launch;

    function automatic logic [6:0] glyph_slot(input logic [3:0] g, input logic [2:0] r);
        return 7'(g * `DMD_GLYPH_ROWS) + {4'h0, r};
    endfunction

    // Every host pin crosses two flip-flops before any logic sees it.
    always_ff @(posedge clk_sys)
    begin
        if (!resetn) begin
            sync1_q   <= 17'h1c000;
            sync2_q   <= 17'h1c000;
            wr_prev_q <= 1'b1;
        end else begin
            sync1_q   <= {chip_enable_n, write_n, read_n, flash_region_select_n,
                          region_select_hi, region_select_lo, sub_address, data_in};
            sync2_q   <= sync1_q;
            wr_prev_q <= sync2_q[15];
        end
    end

    assign ce_n_s    = sync2_q[16];
    assign wr_n_s    = sync2_q[15];
    assign rd_n_s    = sync2_q[14];
    assign sub_s     = sync2_q[10:8];
    assign din_s     = sync2_q[7:0];
    assign area_s    = dmd_decode(sync2_q[13], sync2_q[12], sync2_q[11]);
    assign wr_take   = wr_n_s && !wr_prev_q && !ce_n_s && resetn;
    assign rd_active = !ce_n_s && !rd_n_s && wr_n_s;

    assign brightness_code = attribute_control_word_q[`DMD_CW_BRIGHT_MSB:0];
    assign flash_enable    = attribute_control_word_q[`DMD_CW_FLASH_BIT];
    assign blink_enable    = attribute_control_word_q[`DMD_CW_BLINK_BIT];
    assign self_test_start = wr_take && area_s == DMD_AREA_CTRL && din_s[`DMD_CW_TEST_BIT];
    assign test_launch     = self_test_start && !test_busy;

    dmd_divider #(
        .DISP_DIV   (DISP_DIV),
        .FLASH_DIV  (FLASH_DIV),
        .TEST_TICKS (TEST_TICKS)
    ) u_divider (
        .clk_sys     (clk_sys),
        .resetn      (resetn),
        .test_start  (test_launch),
        .disp_tick   (disp_tick),
        .flash_phase (flash_phase),
        .test_busy   (test_busy),
        .test_count  (test_count),
        .test_done   (test_done)
    );

    always_ff @(posedge clk_sys)
    begin
        if (!resetn) begin
            custom_glyph_pointer_q <= `DMD_PTR_RESET;
        end else if (test_done) begin
            custom_glyph_pointer_q <= `DMD_PTR_AFTER_TEST;
        end else if (wr_take && area_s == DMD_AREA_POINTER) begin
            custom_glyph_pointer_q <= din_s[3:0];
        end
    end

    // Glyph memory has no reset; software defines every row it uses.
    always_ff @(posedge clk_sys)
    begin
        if (wr_take && area_s == DMD_AREA_GLYPH && sub_s < 3'(`DMD_GLYPH_ROWS)) begin
            glyph_mem[glyph_slot(custom_glyph_pointer_q, sub_s)] <= din_s[4:0];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn || clear_go_q || test_done) begin
            flash_flags_q <= 8'h00;
        end else if (wr_take && area_s == DMD_AREA_FLASH) begin
            flash_flags_q[sub_s] <= din_s[0];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn || clear_go_q || test_done) begin
            for (int i = 0; i < 8; i++)
                char_mem[i] <= `DMD_BLANK_CHAR;
        end else if (wr_take && area_s == DMD_AREA_CHAR) begin
            char_mem[sub_s] <= din_s;
        end
    end

    // The clear runs in the cycle after the write; bit 7 is held for three
    // display ticks so a read in that window still sees the clear pending.
    always_ff @(posedge clk_sys)
    begin
        if (!resetn) begin
            clear_go_q  <= 1'b0;
            clear_cnt_q <= 2'h0;
        end else begin
            clear_go_q <= wr_take && area_s == DMD_AREA_CTRL && din_s[`DMD_CW_CLEAR_BIT];
            if (clear_go_q) begin
                clear_cnt_q <= 2'h0;
            end else if (disp_tick && attribute_control_word_q[`DMD_CW_CLEAR_BIT]) begin
                clear_cnt_q <= clear_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn) begin
            attribute_control_word_q <= `DMD_CW_RESET;
        end else if (test_done) begin
            attribute_control_word_q <= {2'b00, attribute_control_word_q[`DMD_CW_RESULT_BIT],
                                         5'h00};
        end else if (test_busy && test_count == 18'(`DMD_ROM_STEPS) && disp_tick) begin
            attribute_control_word_q[`DMD_CW_RESULT_BIT] <= sum_q == ROM_SUM;
        end else if (wr_take && area_s == DMD_AREA_CTRL && !test_busy) begin
            attribute_control_word_q <= {din_s[7:6], attribute_control_word_q[`DMD_CW_RESULT_BIT],
                                         din_s[4:0]};
        end else if (disp_tick && attribute_control_word_q[`DMD_CW_CLEAR_BIT]
                     && clear_cnt_q == 2'(`DMD_CLEAR_TICKS - 1)) begin
            attribute_control_word_q[`DMD_CW_CLEAR_BIT] <= 1'b0;
        end
    end

    // First routine: walk the font through every code and sum its words.
    always_ff @(posedge clk_sys)
    begin
        if (!resetn || test_launch) begin
            sum_q <= 16'h0000;
        end else if (test_busy && disp_tick && test_count < 18'(`DMD_ROM_STEPS)) begin
            sum_q <= sum_q + {8'h00, dmd_font_word(test_count[6:0])};
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn) begin
            pwm_q <= 4'h0;
        end else if (disp_tick) begin
            pwm_q <= (pwm_q == 4'he) ? 4'h0 : pwm_q + 4'h1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn) begin
            digit_on       <= 8'h00;
            test_pattern   <= 1'b0;
            test_inverse   <= 1'b0;
            self_test_busy <= 1'b0;
        end else begin
            self_test_busy <= test_busy;
            // The visual routine follows the checksum and its two patterns share the rest
            // of the test about equally, so each stays up for about 2.3 seconds.
            test_pattern   <= test_busy && test_count >= 18'(`DMD_ROM_STEPS);
            test_inverse   <= test_busy && test_count >= 18'(TEST_TICKS / 2);
            for (int i = 0; i < 8; i++) begin
                if (test_busy)
                    digit_on[i] <= 1'b1;
                else if (brightness_code == `DMD_BRIGHT_BLANK || pwm_q >= dmd_duty(brightness_code))
                    digit_on[i] <= 1'b0;
                else if (blink_enable)
                    digit_on[i] <= flash_phase;
                else if (flash_enable && flash_flags_q[i])
                    digit_on[i] <= flash_phase;
                else
                    digit_on[i] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn) begin
            scan_char <= `DMD_BLANK_CHAR;
            scan_dots <= 5'h00;
        end else begin
            scan_char <= char_mem[scan_digit];
            if (scan_row < 3'(`DMD_GLYPH_ROWS))
                scan_dots <= glyph_mem[glyph_slot(scan_glyph, scan_row)];
            else
                scan_dots <= 5'h00;
        end
    end

    // Host reads; during the self test the bus still answers with the current register values.
    always_ff @(posedge clk_sys)
    begin
        if (!resetn) begin
            data_out <= 8'h00;
            data_oe  <= 1'b0;
        end else begin
            data_oe <= rd_active;
            unique case (area_s)
                DMD_AREA_FLASH:   data_out <= {7'h00, flash_flags_q[sub_s]};
                DMD_AREA_POINTER: data_out <= {4'h0, custom_glyph_pointer_q};
                DMD_AREA_GLYPH:
                    data_out <= (sub_s < 3'(`DMD_GLYPH_ROWS))
                        ? {3'h0, glyph_mem[glyph_slot(custom_glyph_pointer_q, sub_s)]}
                        : 8'h00;
                DMD_AREA_CTRL:    data_out <= attribute_control_word_q;
                DMD_AREA_CHAR:
                    data_out <= char_mem[sub_s][7]
                        ? {4'h8, char_mem[sub_s][3:0]}
                        : char_mem[sub_s];
            endcase
        end
    end

endmodule

`default_nettype wire

/* logic/dmd_divider.sv */
// Shared display-rate divider: display tick, flash phase and self-test sequencer.
// Assumes one system clock; the display rate is a one-cycle enable and the flash rate a toggling phase level.
`timescale 1ns/1ps
`default_nettype none

module dmd_divider
    import dmd_pkg::*;
#(
    parameter int DISP_DIV   = `DMD_DISP_DIV,
    parameter int FLASH_DIV  = `DMD_FLASH_DIV,
    parameter int TEST_TICKS = `DMD_TEST_TICKS
)
(
    input  wire logic        clk_sys,     // System clock.
    input  wire logic        resetn,      // Synchronous reset, active low.
    input  wire logic        test_start,  // Pulse that launches the self test.
    output logic             disp_tick,   // One pulse per display clock period.
    output logic             flash_phase, // Flash and blink phase, period FLASH_DIV ticks.
    output logic             test_busy,   // Self test running.
    output logic [17:0]      test_count,  // Display ticks since self-test launch.
    output logic             test_done    // Pulse at the end of the self test.
);

    logic [15:0] pre_q;
    logic [15:0] flash_cnt_q;

    // Prescaler from system clock to display clock.
    always_ff @(posedge clk_sys)
    begin
        if (!resetn) begin
            pre_q     <= 16'h0000;
            disp_tick <= 1'b0;
        end else if (pre_q == 16'(DISP_DIV - 1)) begin
            pre_q     <= 16'h0000;
            disp_tick <= 1'b1;
        end else begin
            pre_q     <= pre_q + 16'h0001;
            disp_tick <= 1'b0;
        end
    end

    // Half of the flash period per phase; reset restarts it so that several
    // displays reset together stay in step.
    always_ff @(posedge clk_sys)
    begin
        if (!resetn) begin
            flash_cnt_q <= 16'h0000;
            flash_phase <= 1'b0;
        end else if (disp_tick) begin
            if (flash_cnt_q == 16'(FLASH_DIV / 2 - 1)) begin
                flash_cnt_q <= 16'h0000;
                flash_phase <= ~flash_phase;
            end else begin
                flash_cnt_q <= flash_cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!resetn) begin
            test_busy  <= 1'b0;
            test_count <= 18'h00000;
            test_done  <= 1'b0;
        end else begin
            test_done <= 1'b0;
            if (!test_busy) begin
                if (test_start) begin
                    test_busy  <= 1'b1;
                    test_count <= 18'h00000;
                end
            end else if (disp_tick) begin
                if (test_count == 18'(TEST_TICKS - 1)) begin
                    test_busy <= 1'b0;
                    test_done <= 1'b1;
                end else begin
                    test_count <= test_count + 18'h00001;
                end
            end
        end
    end

endmodule

`default_nettype wire

/* logic/dmd_pkg.sv */
// Types and shared functions of the display attribute block.
// Assumes dmd_regs.svh is on the include path.
`default_nettype none
`include "dmd_regs.svh"

package dmd_pkg;

    typedef enum logic [2:0] {
        DMD_AREA_FLASH,
        DMD_AREA_POINTER,
        DMD_AREA_GLYPH,
        DMD_AREA_CTRL,
        DMD_AREA_CHAR
    } dmd_area_t;

    // Flash select low wins over both region lines.
    function automatic dmd_area_t dmd_decode(input logic fl_n, input logic hi, input logic lo);
        if (!fl_n)
            return DMD_AREA_FLASH;
        case ({hi, lo})
            2'b00:   return DMD_AREA_POINTER;
            2'b01:   return DMD_AREA_GLYPH;
            2'b10:   return DMD_AREA_CTRL;
            default: return DMD_AREA_CHAR;
        endcase
    endfunction

    // On-slots out of fifteen for each brightness code.
    function automatic logic [3:0] dmd_duty(input logic [2:0] code);
        case (code)
            3'h0:    return 4'hf;
            3'h1:    return 4'hc;
            3'h2:    return 4'h8;
            3'h3:    return 4'h6;
            3'h4:    return 4'h4;
            3'h5:    return 4'h3;
            3'h6:    return 4'h2;
            default: return 4'h0;
        endcase
    endfunction

    // Stand-in font word; the mask font itself lives in the scan logic.
    function automatic logic [7:0] dmd_font_word(input logic [6:0] code);
        return {code[3:0] ^ code[6:3], code[6:3] + code[3:0]};
    endfunction

    function automatic logic [15:0] dmd_font_sum();
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < `DMD_ROM_STEPS; i++)
            s = s + {8'h00, dmd_font_word(7'(i))};
        return s;
    endfunction

endpackage

`default_nettype wire

/* logic/dmd_regs.svh */
// Field positions, reset values and timing counts of the display attribute block.
// Assumes a 40 MHz system clock. Included by its bare name.
`ifndef DMD_REGS_SVH
`define DMD_REGS_SVH

`define DMD_CW_BRIGHT_MSB   2
`define DMD_CW_FLASH_BIT    3
`define DMD_CW_BLINK_BIT    4
`define DMD_CW_RESULT_BIT   5
`define DMD_CW_TEST_BIT     6
`define DMD_CW_CLEAR_BIT    7
`define DMD_CW_RESET        8'h00
`define DMD_BLANK_CHAR      8'h20
`define DMD_PTR_AFTER_TEST  4'hf
`define DMD_PTR_RESET       4'h0
`define DMD_BRIGHT_BLANK    3'h7
`define DMD_GLYPH_ROWS      7
`define DMD_SYS_CLK_HZ      40000000
`define DMD_DISP_CLK_HZ     57344
`define DMD_DISP_DIV        (`DMD_SYS_CLK_HZ / `DMD_DISP_CLK_HZ)
`define DMD_FLASH_DIV       28672
`define DMD_TEST_TICKS      262144
`define DMD_CLEAR_TICKS     3
`define DMD_ROM_STEPS       128

`endif

/* verification/dmd_attr_regs_checker.sv */
// Concurrent checks on the host and scan ports of the display attribute block.
// Assumes one clock domain and the synchronous active-low reset of the block.
`timescale 1ns/1ps
`default_nettype none

module dmd_attr_regs_checker #(
    parameter int DISP_DIV   = 697,
    parameter int TEST_TICKS = 262144
)
(
    input wire logic       clk_sys,        // System clock.
    input wire logic       resetn,         // Synchronous reset, active low.
    input wire logic       chip_enable_n,  // Chip select pin.
    input wire logic       write_n,        // Write strobe pin.
    input wire logic       read_n,         // Read strobe pin.
    input wire logic       data_oe,        // Data bus drive enable.
    input wire logic [2:0] scan_row,       // Scan row request.
    input wire logic [4:0] scan_dots,      // Scanned glyph row.
    input wire logic [7:0] scan_char,      // Scanned character entry.
    input wire logic [7:0] digit_on,       // Per-digit enable.
    input wire logic       self_test_busy  // Self test running.
);
    // The tick phase at launch is free, so the test length gets one tick of slack.
    localparam int LEN_LO = (TEST_TICKS - 1) * DISP_DIV;
    localparam int LEN_HI = (TEST_TICKS + 1) * DISP_DIV + 2;
    logic [31:0] busy_cnt_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    always_ff @(posedge clk_sys)
    begin
        if (!resetn || !self_test_busy)
            busy_cnt_q <= '0;
        else
            busy_cnt_q <= busy_cnt_q + 32'h1;
    end

    AST_RESET_STATE:
        assert property ($rose(resetn) |-> !data_oe && !self_test_busy
            && digit_on == 8'h00 && scan_char == 8'h20) else $error("reset state wrong");
    AST_READ_DRIVES:
        assert property ((!chip_enable_n && !read_n && write_n) [*4] |-> data_oe)
        else $error("read held but bus not driven");
    AST_OE_NEEDS_READ:
        assert property (data_oe |-> $past(chip_enable_n, 3) == 1'b0
            && $past(read_n, 3) == 1'b0) else $error("bus driven without a read");
    AST_OE_NOT_ON_WRITE:
        assert property (data_oe |-> $past(write_n, 3)) else $error("bus driven in a write");
    AST_ROW7_DARK:
        assert property ((scan_row == 3'h7) [*3] |-> scan_dots == 5'h00)
        else $error("row beyond seven shows dots");
    AST_TEST_LEN_MIN:
        assert property ($fell(self_test_busy) |-> busy_cnt_q >= LEN_LO)
        else $error("self test ended early");
    AST_TEST_LEN_MAX:
        assert property (busy_cnt_q <= LEN_HI) else $error("self test ran too long");
    AST_TEST_END_BLANK:
        assert property ($fell(self_test_busy) |-> ##[1:3] scan_char == 8'h20)
        else $error("character memory not blank after test");

    COV_READ: cover property ($rose(data_oe));
    COV_TEST: cover property ($fell(self_test_busy));
    COV_DOTS: cover property (scan_dots != 5'h00);
endmodule

bind dmd_attr_regs dmd_attr_regs_checker #(.DISP_DIV(DISP_DIV), .TEST_TICKS(TEST_TICKS)) i_chk (
    .clk_sys(clk_sys), .resetn(resetn), .chip_enable_n(chip_enable_n), .write_n(write_n),
    .read_n(read_n), .data_oe(data_oe), .scan_row(scan_row), .scan_dots(scan_dots),
    .scan_char(scan_char), .digit_on(digit_on), .self_test_busy(self_test_busy));

`default_nettype wire

/* verification/dmd_attr_regs_tb.sv */
// Self-checking bench for the display attribute block through its host pins.
// Assumes short divider parameters so flash, blink and self test fit a short run.
`timescale 1ns/1ps
`default_nettype none

module dmd_attr_regs_tb;
    localparam int DDIV = 2;
    localparam int FDIV = 8;
    localparam int TT   = 300;
    localparam logic [2:0] FLS = 3'b010, PTR = 3'b100, GLY = 3'b101, CTL = 3'b110, CHR = 3'b111;
    logic       clk_sys, resetn, ce_n, wr_n, rd_n, fl_n, hi, lo, doe, tpat, tinv, busy;
    logic [2:0] sa, scan_digit, scan_row;
    logic [3:0] scan_glyph;
    logic [4:0] scan_dots;
    logic [7:0] din, dout, scan_char, digit_on, v;
    logic [1:0] seen;
    int         n_errors = 0;
    int         samples_checked = 0;
    int         cycles = 0;

    dmd_attr_regs #(.DISP_DIV(DDIV), .FLASH_DIV(FDIV), .TEST_TICKS(TT)) i_dut (
        .clk_sys(clk_sys), .resetn(resetn), .chip_enable_n(ce_n), .write_n(wr_n),
        .read_n(rd_n), .flash_region_select_n(fl_n), .region_select_hi(hi),
        .region_select_lo(lo), .sub_address(sa), .data_in(din), .data_out(dout),
        .data_oe(doe), .scan_digit(scan_digit), .scan_glyph(scan_glyph), .scan_row(scan_row),
        .scan_char(scan_char), .scan_dots(scan_dots), .digit_on(digit_on),
        .test_pattern(tpat), .test_inverse(tinv), .self_test_busy(busy));

    dmd_host_model i_host (
        .clk_sys(clk_sys), .data_out(dout), .data_oe(doe), .chip_enable_n(ce_n),
        .write_n(wr_n), .read_n(rd_n), .flash_region_select_n(fl_n), .region_select_hi(hi),
        .region_select_lo(lo), .sub_address(sa), .data_in(din));

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic final_report();
        $display("checked=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors = n_errors + 1;
            final_report();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] sel, input logic [2:0] adr, input logic [7:0] d);
        logic [7:0] x;
        i_host.access(1'b1, sel, adr, d, x);
    endtask

    task automatic rd(input logic [2:0] sel, input logic [2:0] adr, output logic [7:0] q);
        i_host.access(1'b0, sel, adr, 8'h00, q);
    endtask

    // Both enable patterns must appear and nothing else may.
    task automatic watch(input logic [7:0] cw, input logic [7:0] a, input logic [7:0] b);
        logic sa_seen, sb_seen, bad;
        wr(CTL, 3'h0, cw);
        {sa_seen, sb_seen, bad} = 3'b000;
        repeat (48)
        begin
            @(negedge clk_sys);
            sa_seen |= digit_on === a;
            sb_seen |= digit_on === b;
            bad |= digit_on !== a && digit_on !== b;
        end
        chk({6'h00, sa_seen && sb_seen, bad}, 8'h02);
    endtask

    // Two whole dimming periods of fifteen display ticks give an exact lit count.
    task automatic duty(input logic [7:0] cw, input logic [7:0] exp);
        logic [7:0] n;
        wr(CTL, 3'h0, cw);
        n = 8'h00;
        repeat (30 * DDIV)
        begin
            @(negedge clk_sys);
            n += 8'(digit_on === 8'hff);
        end
        chk(n, exp);
    endtask

    task automatic wait_busy(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy !== lvl && n < lim)
        begin
            @(negedge clk_sys);
            seen |= {tpat && !tinv, tinv};
            n++;
        end
        chk({7'h00, busy}, {7'h00, lvl});
    endtask

    initial
    begin
        {resetn, scan_digit, scan_glyph, scan_row} = '0;
        repeat (4) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (3) @(negedge clk_sys);
        rd(CTL, 3'h0, v); chk(v, 8'h00);
        wr(PTR, 3'h0, 8'ha5); rd(PTR, 3'h0, v); chk(v & 8'h0f, 8'h05);
        for (int r = 0; r < 7; r++)
            wr(GLY, 3'(r), 8'he0 | 8'(r * 5 + 3));
        wr(PTR, 3'h0, 8'h06); wr(GLY, 3'h0, 8'h00); wr(PTR, 3'h0, 8'h05);
        scan_glyph = 4'h5;
        for (int r = 0; r < 7; r++)
        begin
            rd(GLY, 3'(r), v); chk(v & 8'h1f, 8'(r * 5 + 3) & 8'h1f);
            scan_row = 3'(r);
            repeat (2) @(negedge clk_sys);
            chk({3'h0, scan_dots}, 8'(r * 5 + 3) & 8'h1f);
        end
        scan_row = 3'h7;
        rd(GLY, 3'h7, v); chk(v, 8'h00);
        {scan_glyph, scan_row} = {4'h6, 3'h0};
        repeat (2) @(negedge clk_sys);
        chk({3'h0, scan_dots}, 8'h00);
        for (int d = 0; d < 8; d++)
            wr(FLS, 3'(d), 8'hfe | 8'(d & 1));
        for (int d = 0; d < 8; d++)
        begin
            rd(FLS, 3'(d), v); chk(v & 8'h01, 8'(d & 1));
        end
        rd(CTL, 3'h0, v); chk(v, 8'h00);
        wr(CTL, 3'h0, 8'h3f); rd(CTL, 3'h0, v); chk(v, 8'h1f);
        watch(8'h08, 8'hff, 8'h55);
        watch(8'h18, 8'hff, 8'h00);
        watch(8'h07, 8'h00, 8'h00);
        watch(8'h00, 8'hff, 8'hff);
        duty(8'h02, 8'd32);
        duty(8'h06, 8'd8);
        wr(CHR, 3'h0, 8'h41); wr(CHR, 3'h1, 8'h83);
        rd(CHR, 3'h0, v); chk(v, 8'h41);
        rd(CHR, 3'h1, v); chk(v, 8'h83);
        wr(CTL, 3'h0, 8'h80);
        repeat (8) @(negedge clk_sys);
        rd(CHR, 3'h0, v); chk(v, 8'h20);
        rd(FLS, 3'h1, v); chk(v & 8'h01, 8'h00);
        rd(CTL, 3'h0, v); chk(v, 8'h00);
        seen = 2'b00;
        wr(FLS, 3'h2, 8'h01); wr(PTR, 3'h0, 8'h03); wr(CHR, 3'h0, 8'h41);
        wr(CTL, 3'h0, 8'h4c);
        wait_busy(1'b1, 20);
        wait_busy(1'b0, 2 * TT * DDIV);
        chk({4'h0, seen, tpat, tinv}, 8'h0c);
        rd(CTL, 3'h0, v); chk(v, 8'h20);
        rd(PTR, 3'h0, v); chk(v & 8'h0f, 8'h0f);
        rd(FLS, 3'h2, v); chk(v & 8'h01, 8'h00);
        rd(CHR, 3'h0, v); chk(v, 8'h20);
        wr(CTL, 3'h0, 8'h00); rd(CTL, 3'h0, v); chk(v, 8'h20);
        resetn = 1'b0;
        repeat (4) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (3) @(negedge clk_sys);
        rd(CTL, 3'h0, v); chk(v, 8'h00);
        final_report();
    end
endmodule

`default_nettype wire

/* verification/dmd_host_model.sv */
// Host processor model on the display's parallel pin bus.
// Assumes pins change on the falling clock edge and the block samples on the rising one.
`timescale 1ns/1ps
`default_nettype none

module dmd_host_model
(
    input  wire logic       clk_sys,               // System clock.
    input  wire logic [7:0] data_out,              // Read data from the block.
    input  wire logic       data_oe,               // Block drives the bus.
    output logic            chip_enable_n,         // Chip select.
    output logic            write_n,               // Write strobe.
    output logic            read_n,                // Read strobe.
    output logic            flash_region_select_n, // Flash memory select.
    output logic            region_select_hi,      // Upper region line.
    output logic            region_select_lo,      // Lower region line.
    output logic      [2:0] sub_address,           // Digit or row.
    output logic      [7:0] data_in                // Bus level seen by the block.
);
    logic [7:0] drv_q;
    logic       drv_en;

    // A released bus shows the inverse of the last value so no stale data can pass.
    assign data_in = data_oe ? data_out : (drv_en ? drv_q : ~drv_q);

    initial
    begin
        {chip_enable_n, write_n, read_n, drv_en} = 4'b1110;
        {flash_region_select_n, region_select_hi, region_select_lo} = 3'b111;
        sub_address = 3'h0;
        drv_q = 8'h00;
    end

    // Strobes need two sync flops, so every phase is held for several clocks.
    task automatic access(input logic wr, input logic [2:0] sel, input logic [2:0] adr,
                          input logic [7:0] wdat, output logic [7:0] rdat);
        @(negedge clk_sys);
        {flash_region_select_n, region_select_hi, region_select_lo} = sel;
        sub_address = adr;
        drv_q = wdat;
        drv_en = wr;
        chip_enable_n = 1'b0;
        write_n = !wr;
        read_n = wr;
        repeat (4) @(negedge clk_sys);
        rdat = data_out;
        write_n = 1'b1;
        read_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        chip_enable_n = 1'b1;
        drv_en = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
endmodule

`default_nettype wire
